// ==== src/sid_core.sv ====
// subtract instruction datapath: literal and file-register forms, four-phase cycle
// assumes the program word is stable from Q1 to Q4 and file reads return
// data combinationally in the cycle the address is shown
// How it works
// - literal minus working register into working register
// - file value minus working register, 8-bit
// - file form decoded from top bits 010111
// - destination bit picks working or file register
// - bank bit picks shared bank or pointer
// - extended set, shared, address<=95 uses indexed offset
// - both forms update all five flags
// - decode, read, compute, write in Q1..Q4
module sid_core
   import sid_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] instr_word,
   input  wire logic        ext_set_en,
   input  wire logic [3:0]  bank_pointer_register,
   input  wire logic [11:0] index_base,
   input  wire logic [7:0]  file_rd_data,
   output logic [11:0]      file_addr,
   output logic             file_rd_en,
   output logic             file_wr_en,
   output logic [7:0]       file_wr_data,
   output logic [7:0]       acc_ff,
   output sid_flags_t       flags_ff,
   output sid_phase_t       phase_ff,
   output logic             instr_done
);
   sid_dec_t   dec_ff;      // decoded instruction held from Q1
   sid_dec_t   nxt_dec;     // decode of the current word
   logic [7:0] opnd_ff;     // minuend captured in Q2
   logic [7:0] res_ff;      // difference from Q3
   sid_flags_t res_flags_ff;// flags from Q3
   logic [11:0] addr_calc;  // effective file address
   logic [7:0] diff_w;      // subtractor result
   sid_flags_t flags_w;     // subtractor flags
   logic       active;      // current instruction is a subtract

   // instruction decode
   always_comb begin
      nxt_dec          = '0;
      nxt_dec.is_lit   = (instr_word[15:8] == SID_LIT_OPCODE);
      nxt_dec.is_file  = (instr_word[SID_OP6_MSB -: 6] == SID_FILE_OPCODE);
      nxt_dec.dest_f   = instr_word[SID_DEST_BIT];
      nxt_dec.bank_sel = instr_word[SID_BANK_BIT];
      nxt_dec.field    = instr_word[7:0];
   end

   // effective address of the file operand
   always_comb begin
      if (dec_ff.bank_sel) begin
         addr_calc = {bank_pointer_register, dec_ff.field};
      end else if (ext_set_en && (dec_ff.field <= SID_IDX_LIMIT)) begin
         addr_calc = index_base + {4'h0, dec_ff.field};
      end else if (dec_ff.field <= SID_IDX_LIMIT) begin
         addr_calc = {4'h0, dec_ff.field};
      end else begin
         addr_calc = SID_ACCESS_HI_BASE | {4'h0, dec_ff.field};
      end
   end

   assign active = dec_ff.is_lit | dec_ff.is_file;

   // phase sequencer
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         phase_ff <= SID_Q1;
      end else begin
         unique case (phase_ff)
            SID_Q1: phase_ff <= SID_Q2;
            SID_Q2: phase_ff <= SID_Q3;
            SID_Q3: phase_ff <= SID_Q4;
            SID_Q4: phase_ff <= SID_Q1;
         endcase
      end
   end

   // decode register, loaded in Q1
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dec_ff <= '0;
      end else if (phase_ff == SID_Q1) begin
         dec_ff <= nxt_dec;
      end
   end

   // operand read in Q2
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         opnd_ff <= 8'h00;
      end else if (phase_ff == SID_Q2) begin
         // literal value or file register as minuend
         opnd_ff <= dec_ff.is_lit ? dec_ff.field : file_rd_data;
      end
   end

   sid_sub8 i_sid_sub8 (
      .minuend    (opnd_ff),
      .subtrahend (acc_ff),
      .diff       (diff_w),
      .flags      (flags_w)
   );

   // arithmetic captured in Q3
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         res_ff       <= 8'h00;
         res_flags_ff <= '0;
      end else if (phase_ff == SID_Q3) begin
         res_ff       <= diff_w;
         res_flags_ff <= flags_w;
      end
   end

   // working register written in Q4
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         acc_ff <= SID_ACC_RST;
      end else if (phase_ff == SID_Q4) begin
         if (dec_ff.is_lit || (dec_ff.is_file && !dec_ff.dest_f)) begin
            acc_ff <= res_ff;
         end
      end
   end

   // flags written in Q4 for either form
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         flags_ff <= '0;
      end else if (phase_ff == SID_Q4 && active) begin
         flags_ff <= res_flags_ff;
      end
   end

   // file port: read in Q2, write back in Q4
   always_comb begin
      file_addr    = dec_ff.is_file ? addr_calc : 12'h000;
      file_rd_en   = (phase_ff == SID_Q2) && dec_ff.is_file;
      file_wr_en   = (phase_ff == SID_Q4) && dec_ff.is_file && dec_ff.dest_f;
      file_wr_data = res_ff;
      instr_done   = (phase_ff == SID_Q4) && active;
   end

   // assertions: phase order, results, flags and addressing
   sequence s_q1_to_q4;
      phase_ff == SID_Q1 ##1 phase_ff == SID_Q2 ##1 phase_ff == SID_Q3 ##1 phase_ff == SID_Q4;
   endsequence

   a_phase_order: assert property (@(posedge ref_clk) disable iff (sys_rst)
      phase_ff == SID_Q1 |-> s_q1_to_q4) else $error("phase order broken");

   a_lit_result: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q4 && dec_ff.is_lit) |=> acc_ff == res_ff)
      else $error("literal result lost");

   a_file_dest_w: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q4 && dec_ff.is_file && dec_ff.dest_f) |=> $stable(acc_ff))
      else $error("working register changed on file destination");

   a_file_sub_val: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q3 && dec_ff.is_file) |=> res_ff == 8'($past(opnd_ff) - $past(acc_ff)))
      else $error("file difference wrong");

   a_decode_file: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q1 && instr_word[15:10] == 6'h17) |=> dec_ff.is_file)
      else $error("file form not decoded");

   a_decode_lit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q1 && instr_word[15:8] == 8'h08) |=> dec_ff.is_lit)
      else $error("literal form not decoded");

   a_bank_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (dec_ff.is_file && dec_ff.bank_sel) |-> file_addr[11:8] == bank_pointer_register)
      else $error("bank pointer not used");

   a_indexed_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (dec_ff.is_file && !dec_ff.bank_sel && ext_set_en && dec_ff.field <= 8'h5F)
      |-> file_addr == 12'(index_base + {4'h0, dec_ff.field}))
      else $error("indexed address wrong");

   a_flags_upd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q4 && active) |=> flags_ff.zero == (res_ff == 8'h00)
      && flags_ff.neg == res_ff[7]) else $error("flags not updated");

   a_carry_borrow: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q3 && active) |=> res_flags_ff.carry == ($past(opnd_ff) >= $past(acc_ff)))
      else $error("carry sense wrong");

   // compute in Q3 followed by commit in Q4 of the same instruction
   sequence s_compute_commit;
      phase_ff == SID_Q3 ##1 phase_ff == SID_Q4;
   endsequence

   // literal difference seen in Q3 is what the working register holds afterwards
   a_lit_commit: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q3 && dec_ff.is_lit) |-> s_compute_commit ##1 acc_ff == $past(diff_w, 2))
      else $error("literal difference not committed");

   // minuend capture: literal field at the end of Q2
   a_lit_opnd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q2 && dec_ff.is_lit) |=> opnd_ff == $past(dec_ff.field))
      else $error("literal operand not taken");

   // minuend capture: file read data at the end of Q2
   a_file_opnd: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q2 && dec_ff.is_file) |=> opnd_ff == $past(file_rd_data))
      else $error("file operand not taken");

   // destination bit clear: no file write, result lands in the working register
   a_file_dest_acc: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q4 && dec_ff.is_file && !dec_ff.dest_f) |-> !file_wr_en ##1 acc_ff == $past(res_ff))
      else $error("file result not sent to working register");

   // shared bank without indexing: low part at 000h, high part at F00h
   a_shared_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (dec_ff.is_file && !dec_ff.bank_sel && !ext_set_en)
      |-> file_addr == ((dec_ff.field <= 8'h5F) ? {4'h0, dec_ff.field} : {4'hF, dec_ff.field}))
      else $error("shared bank address wrong");

   // all five flags are taken from the Q3 result
   a_flags_copy: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q4 && active) |=> flags_ff == $past(res_flags_ff))
      else $error("flags not taken from result");

   // signed wrap when operand signs differ and the result leaves the minuend's sign
   a_wrap_sign: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q3 && active) |=> res_flags_ff.signed_wrap ==
      (($past(opnd_ff[7]) != $past(acc_ff[7])) && (res_ff[7] != $past(opnd_ff[7]))))
      else $error("signed wrap wrong");

   // nibble carry set when the low nibble needs no borrow
   a_nibble_borrow: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q3 && active) |=> res_flags_ff.nibble_carry ==
      ($past(opnd_ff[3:0]) >= $past(acc_ff[3:0])))
      else $error("nibble carry wrong");

   // a foreign word leaves working register and flags alone
   a_refuse_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
      (phase_ff == SID_Q4 && !active) |=> $stable(flags_ff) && $stable(acc_ff))
      else $error("state changed on a foreign word");

   // a foreign word never drives the file port or the done pulse
   a_refuse_quiet: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !active |-> !file_rd_en && !file_wr_en && !instr_done)
      else $error("port active on a foreign word");
endmodule

// ==== src/sid_pkg.sv ====
// package for the subtract instruction datapath: opcodes, address limits, phase codes
// assumes a single 200 MHz core clock and a four-phase instruction cycle
package sid_pkg;
   localparam int          SID_CLK_MHZ        = 200;  // core clock rate
   localparam logic [7:0]  SID_LIT_OPCODE     = 8'h08; // upper byte of literal form
   localparam logic [5:0]  SID_FILE_OPCODE    = 6'h17; // upper six bits 010111
   localparam int          SID_OP6_MSB        = 15;   // opcode field top bit
   localparam int          SID_DEST_BIT       = 9;    // destination select position
   localparam int          SID_BANK_BIT       = 8;    // bank select position
   localparam logic [7:0]  SID_IDX_LIMIT      = 8'h5F; // highest indexed offset address
   localparam logic [7:0]  SID_ACC_RST        = 8'h00; // working register after reset
   localparam logic [3:0]  SID_BANK_RST       = 4'h0;  // bank pointer after reset
   localparam logic [11:0] SID_ACCESS_HI_BASE = 12'hF00; // upper half of shared bank

   // four phases of one instruction cycle
   typedef enum logic [1:0] {
      SID_Q1 = 2'b00,
      SID_Q2 = 2'b01,
      SID_Q3 = 2'b10,
      SID_Q4 = 2'b11
   } sid_phase_t;

   // status flags of a subtract
   typedef struct packed {
      logic neg;         // bit 7 of result
      logic signed_wrap; // signed overflow
      logic zero;        // result is zero
      logic nibble_carry;// no borrow out of bit 3
      logic carry;       // no borrow out of bit 7
   } sid_flags_t;

   // decoded instruction
   typedef struct packed {
      logic       is_lit;   // literal minus working register
      logic       is_file;  // file minus working register
      logic       dest_f;   // result back to file register
      logic       bank_sel; // use bank pointer
      logic [7:0] field;    // literal or file address
   } sid_dec_t;
endpackage

// ==== src/sid_sub8.sv ====
// 8-bit subtractor that produces difference and status flags
// assumes purely combinational use inside the datapath
module sid_sub8
   import sid_pkg::*;
(
   input  wire logic [7:0] minuend,
   input  wire logic [7:0] subtrahend,
   output logic [7:0]      diff,
   output sid_flags_t      flags
);
   logic [8:0] full_d; // nine-bit difference, top bit is borrow
   logic [4:0] low_d;  // low nibble difference

   // two's complement subtraction with borrow tracking
   always_comb begin
      full_d             = {1'b0, minuend} - {1'b0, subtrahend};
      low_d              = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
      diff               = full_d[7:0];
      flags.neg          = full_d[7];
      flags.zero         = (full_d[7:0] == 8'h00);
      flags.carry        = ~full_d[8];
      flags.nibble_carry = ~low_d[4];
      // overflow when signs differ and result sign leaves the minuend's
      flags.signed_wrap  = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_d[7]);
   end
endmodule

// ==== verification/test_subtract_instruction_datapath.sv ====
// self-checking bench for sid_core: literal and file forms, addressing, refusal
// assumes the free-running four-phase cycle and the port timing of the core
module test_subtract_instruction_datapath
   import sid_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk, sys_rst, ext_set_en, file_rd_en, file_wr_en, instr_done;
   logic [15:0] instr_word;
   logic [3:0]  bank_pointer_register;
   logic [11:0] index_base, file_addr;
   logic [7:0]  file_rd_data, file_wr_data, acc_ff;
   logic [7:0]  w_m;       // expected working register
   sid_flags_t  flags_ff, f_m; // design flags, expected flags
   sid_phase_t  phase_ff;
   int          errors, n_tests;

   sid_core i_sid_core (.ref_clk, .sys_rst, .instr_word, .ext_set_en, .bank_pointer_register,
      .index_base, .file_rd_data, .file_addr, .file_rd_en, .file_wr_en, .file_wr_data,
      .acc_ff, .flags_ff, .phase_ff, .instr_done);

   // 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task cmp_fl(input sid_flags_t exp, input sid_flags_t got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("wrong value flags expected %b seen %b", exp, got);
      end
   endtask

   task close_out;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // one clock, then let the edge's updates land
   task step;
      @(posedge ref_clk);
      #1;
   endtask

   // bounded wait for the decode phase
   task to_q1;
      int k;
      k = 0;
      while (phase_ff !== SID_Q1) begin
         step();
         k++;
         if (k > 8) begin
            errors++;
            close_out();
         end
      end
   endtask

   // runs one subtract and checks the Q2 read, the Q4 write and the following Q1 state against the reference arithmetic
   task exec(input logic [15:0] wd, input logic [7:0] rd, input logic [11:0] ad, input logic fil);
      logic [7:0] m, d;
      logic       dst;
      to_q1();
      instr_word = wd;
      file_rd_data = rd;
      m = fil ? rd : wd[7:0];
      d = m - w_m;
      f_m = '{d[7], (m[7] != w_m[7]) && (d[7] != m[7]), d == 8'h00, m[3:0] >= w_m[3:0], m >= w_m};
      dst = fil & wd[SID_DEST_BIT];
      step();
      cmp("rd_en", 12'(fil), 12'(file_rd_en));
      if (fil) cmp("addr", ad, file_addr);
      step();
      step();
      cmp("wr_en", 12'(dst), 12'(file_wr_en));
      if (dst) cmp("wr_data", 12'(d), 12'(file_wr_data));
      cmp("done", 12'h001, 12'(instr_done));
      if (!dst) w_m = d;
      step();
      cmp("acc", 12'(w_m), 12'(acc_ff));
      cmp_fl(f_m, flags_ff);
   endtask

   // literal form across carry, zero, negative, overflow and nibble cases
   task t_literal;
      logic [7:0] ks [7];
      ks = '{8'h05, 8'h02, 8'hFD, 8'h01, 8'h80, 8'h10, 8'hFF};
      foreach (ks[i]) exec({SID_LIT_OPCODE, ks[i]}, 8'hA5, 12'h000, 1'b0);
      $display("literal test done");
   endtask

   // file form: both destinations, shared bank halves, bank pointer, indexed wrap
   task t_file;
      ext_set_en = 1'b0;
      exec({SID_FILE_OPCODE, 2'b00, 8'h20}, 8'h40, 12'h020, 1'b1);
      exec({SID_FILE_OPCODE, 2'b10, 8'h80}, 8'h03, 12'hF80, 1'b1);
      exec({SID_FILE_OPCODE, 2'b11, 8'h33}, 8'hC4, 12'h533, 1'b1);
      ext_set_en = 1'b1;
      exec({SID_FILE_OPCODE, 2'b00, 8'h5F}, 8'h7E, 12'h01F, 1'b1);
      exec({SID_FILE_OPCODE, 2'b10, 8'h60}, 8'h00, 12'hF60, 1'b1);
      bank_pointer_register = 4'hA;
      exec({SID_FILE_OPCODE, 2'b11, 8'h10}, 8'h91, 12'hA10, 1'b1);
      $display("file test done");
   endtask

   // other words leave the working register, flags and port strobes untouched
   task t_refuse;
      to_q1();
      instr_word = 16'h5700;
      repeat (4) begin
         step();
         cmp("idle", 12'h000, {9'h000, file_rd_en, file_wr_en, instr_done});
      end
      cmp("acc", 12'(w_m), 12'(acc_ff));
      cmp_fl(f_m, flags_ff);
      $display("refuse test done");
   endtask

   // reset cut into an instruction in Q3 returns to reset state, then a fresh literal runs
   task t_reset_mid;
      to_q1();
      instr_word = {SID_LIT_OPCODE, 8'h3C};
      step();
      step();
      sys_rst = 1'b1;
      step();
      step();
      sys_rst = 1'b0;
      w_m = SID_ACC_RST;
      f_m = '0;
      cmp("mid_acc", 12'(SID_ACC_RST), 12'(acc_ff));
      cmp("mid_phase", 12'(SID_Q1), 12'(phase_ff));
      cmp("mid_idle", 12'h000, {9'h000, file_rd_en, file_wr_en, instr_done});
      cmp_fl(f_m, flags_ff);
      exec({SID_LIT_OPCODE, 8'h3C}, 8'h00, 12'h000, 1'b0);
      $display("reset test done");
   endtask

   initial begin
      errors = 0;
      n_tests = 0;
      w_m = SID_ACC_RST;
      f_m = '0;
      sys_rst = 1'b1;
      ext_set_en = 1'b0;
      instr_word = 16'h0000;
      bank_pointer_register = 4'h5;
      index_base = 12'hFC0;
      file_rd_data = 8'h00;
      repeat (2) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      cmp("rst_acc", 12'(SID_ACC_RST), 12'(acc_ff));
      cmp("rst_phase", 12'(SID_Q1), 12'(phase_ff));
      cmp_fl(f_m, flags_ff);
      t_literal();
      t_file();
      t_refuse();
      t_reset_mid();
      close_out();
   end
endmodule
